// ### design/scb_pkg.sv
package scb_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W          = 8;
  localparam logic [7:0]  OFF_SYSTEM_CTRL = 8'h00;
  localparam logic [7:0]  OFF_WIDTH_SW    = 8'h04;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // ----------------------------------------------------------------
  // system_control fields
  // ----------------------------------------------------------------
  localparam int unsigned BIT_IRQ_ACTIVE  = 27;
  localparam int unsigned BIT_WD_TIMEOUT  = 26;
  localparam int unsigned BIT_WP_VIOL     = 25;
  localparam int unsigned BIT_DEC_CONFL   = 24;
  localparam int unsigned BIT_UCODE_EN    = 23;
  localparam int unsigned BIT_VECTOR_GEN  = 21;
  localparam int unsigned BIT_WP_ERR_EN   = 20;
  localparam int unsigned BIT_LOCK_SPLIT  = 19;
  localparam int unsigned BIT_EXT_WAIT    = 18;
  localparam int unsigned BIT_CONFL_EN    = 17;
  localparam int unsigned BIT_CLEAR_MASK  = 16;
  localparam int unsigned BIT_FRZ_WD      = 15;
  localparam int unsigned BIT_FRZ_T2      = 14;
  localparam int unsigned BIT_FRZ_T1      = 13;
  localparam int unsigned BIT_SYNC_ACC    = 12;
  localparam int unsigned BIT_WD_EN       = 11;
  localparam int unsigned WD_CNT_LO       = 8;
  localparam int unsigned WD_CNT_W        = 3;
  localparam logic [31:0] SYSCTL_RESET    = 32'h0000_0800;
  localparam logic [31:0] SYSCTL_RW_MASK  = 32'h00FF_FF00;
  localparam logic [31:0] SYSCTL_W1C_MASK = 32'h0F00_0000;

  // ----------------------------------------------------------------
  // bus_width_switch fields
  // ----------------------------------------------------------------
  localparam int unsigned BIT_SW_EN       = 0;
  localparam int unsigned BIT_WIDTH_SEL   = 1;
  localparam logic [1:0]  WIDTH_SW_RESET  = 2'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [1:0]  ASYNC_WAITS     = 2'h3;
  localparam logic [1:0]  SYNC_WAITS      = 2'h0;
  localparam logic [1:0]  ONE_WAIT        = 2'h1;
  localparam int unsigned WD_TMR_W        = 15;
  localparam int unsigned WD_BASE_CYCLES  = 128;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } scb_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } scb_axi_rsp_t;

  typedef struct packed {
    logic cycle_start;
    logic cycle_ack;
    logic wp_violation;
    logic cs_conflict;
  } scb_bus_evt_t;

  typedef struct packed {
    logic irq_pending;
    logic lock_active;
    logic bus_granted;
  } scb_core_t;

  typedef struct packed {
    logic       freeze_timer_one;
    logic       freeze_timer_two;
    logic       freeze_watchdog_timer;
    logic       microcode_run;
    logic       bus_clear;
    logic       grant_allow;
    logic       lock_split;
    logic       cs_wait_on_write;
    logic       cs_extra_wait;
    logic [1:0] ext_wait_states;
  } scb_ctl_t;

  typedef enum logic [1:0] {
    SCB_SW_IDLE    = 2'b00,
    SCB_SW_REQ     = 2'b01,
    SCB_SW_APPLY   = 2'b10,
    SCB_SW_RELEASE = 2'b11
  } scb_sw_state_t;

endpackage : scb_pkg

// ### design/scb_top.sv
// Functional notes
// - Bits 27-24 are sticky event flags; write one clears, zero keeps.
// - All four event flags clear on system reset.
// - Interrupt-active flag sets while core has unmasked interrupt pending.
// - Watchdog expiry sets timeout flag and always raises bus error.
// - Write to read-only chip-select region sets write-protect flag.
// - Two chip selects in one cycle set decode-conflict flag.
// - Write-protect violation raises bus error only when enabled; reset 0.
// - Split bit 0: strobes held through locked cycle, grant ignores lock.
// - Split bit 1: strobes split, grant withheld, waits on both halves.
// - No grant while core lock active with split bit 1; split bit resets to zero.
// - External wait bit adds one wait to external-master cycles.
// - Decode conflict raises bus error only when its enable is 1.
// - Bus-clear mask 1 lets interrupt pending drive bus clear.
// - Async access mode (default): external accesses take three waits.
// - Sync mode: external reads may take one wait with wait bit.
// - Setting microcode enable starts communication processor microcode.
// - Three freeze enables for timer one, two, watchdog; reset 0.
// - Enabled watchdog errors unacknowledged cycles; enable resets to 1.
// - Watchdog code 0..7 selects 128 up to 16K cycles.
// - Rising switch enable runs take-bus, apply width, return sequence.
// - Width select 0 gives 8-bit bus, 1 gives 16-bit bus.
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module scb_top #(
  parameter int unsigned WD_BASE = scb_pkg::WD_BASE_CYCLES
) (
  // Clock and reset.
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Register bus.
  input  wire scb_pkg::scb_axi_req_t axi_req,
  output var  scb_pkg::scb_axi_rsp_t axi_rsp,
  // Bus cycle events from chip-select logic.
  input  wire scb_pkg::scb_bus_evt_t bus_evt,
  // Core status.
  input  wire scb_pkg::scb_core_t    core,
  // Control outputs to arbiter, ack generator, timers.
  output var  scb_pkg::scb_ctl_t     ctl,
  output var  logic                  bus_error,
  // Bus width switch.
  output var  logic                  core_bus_request,
  output var  logic                  data_width_16
);
  import scb_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    scb_axi_rsp_t      rsp;
    logic              aw_full;
    logic              w_full;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic [31:0]       sysctl;
    logic [1:0]        wsw;
    logic              sw_en_prev;
    scb_sw_state_t     sw;
    logic              bus_req;
    logic              width16;
    logic              bus_error;
    scb_ctl_t          ctl;
  } scb_top_state_t;

  scb_top_state_t q;
  scb_top_state_t d;
  logic           wd_expire;
  logic [31:0]    wmask;
  logic [31:0]    events;
  logic           do_wr;
  logic           wr_sysctl;
  logic           wr_wsw;

  // ----------------------------------------------------------------
  // Hardware bus watchdog
  // ----------------------------------------------------------------
  // Counter lives in its own module; it only needs the live fields.
  scb_wdog #(
    .BASE_CYCLES (WD_BASE)
  ) u_wdog (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .enable      (q.sysctl[BIT_WD_EN]),
    .count_sel   (q.sysctl[WD_CNT_LO +: WD_CNT_W]),
    .cycle_start (bus_evt.cycle_start),
    .cycle_ack   (bus_evt.cycle_ack),
    .expire      (wd_expire)
  );

  // ----------------------------------------------------------------
  // Byte lane mask
  // ----------------------------------------------------------------
  // Each strobe bit opens one byte of the held write data.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{q.w_strb[gi]}};
    end
  endgenerate

  // ----------------------------------------------------------------
  // Event vector
  // ----------------------------------------------------------------
  // Hardware sets are OR-ed in after the clear so a same-cycle event
  // survives a software clear.
  always_comb begin
    events                 = '0;
    events[BIT_IRQ_ACTIVE] = core.irq_pending;
    events[BIT_WD_TIMEOUT] = wd_expire;
    events[BIT_WP_VIOL]    = bus_evt.wp_violation;
    events[BIT_DEC_CONFL]  = bus_evt.cs_conflict;
  end

  // Write is performed once both address and data are held.
  assign do_wr     = q.aw_full && q.w_full && !q.rsp.bvalid;
  assign wr_sysctl = do_wr && (q.aw_addr == OFF_SYSTEM_CTRL);
  assign wr_wsw    = do_wr && (q.aw_addr == OFF_WIDTH_SW);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d           = q;
    d.bus_error = 1'b0;

    // Address and data channels are taken independently.
    if (axi_req.awvalid && q.rsp.awready) begin
      d.aw_full = 1'b1;
      d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && q.rsp.wready) begin
      d.w_full = 1'b1;
      d.w_data = axi_req.wdata;
      d.w_strb = axi_req.wstrb;
    end
    if (q.rsp.bvalid && axi_req.bready) begin
      d.rsp.bvalid = 1'b0;
    end

    // Perform the write and raise the response.
    if (do_wr) begin
      d.aw_full     = 1'b0;
      d.w_full      = 1'b0;
      d.rsp.bvalid  = 1'b1;
      d.rsp.bresp   = (wr_sysctl || wr_wsw) ? RESP_OKAY : RESP_SLVERR;
    end

    // Control fields take masked data; vector generation is stored
    // as written, software is expected to keep it at zero.
    if (wr_sysctl) begin
      d.sysctl = (q.sysctl & ~(wmask & SYSCTL_RW_MASK))
               | (q.w_data & wmask & SYSCTL_RW_MASK);
    end

    // Status: write one clears, then the events set again.
    d.sysctl = d.sysctl & ~SYSCTL_W1C_MASK
             | (q.sysctl & SYSCTL_W1C_MASK
                & ~(wr_sysctl ? (q.w_data & wmask) : '0))
             | (events & SYSCTL_W1C_MASK);

    // Width switch register sits in the lowest byte lane.
    if (wr_wsw && q.w_strb[0]) begin
      d.wsw = q.w_data[1:0];
    end

    // Read channel: answer drops first, then a new read may land.
    if (q.rsp.rvalid && axi_req.rready) begin
      d.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && q.rsp.arready) begin
      d.rsp.rvalid = 1'b1;
      d.rsp.rresp  = RESP_OKAY;
      unique case (axi_req.araddr)
        OFF_SYSTEM_CTRL: d.rsp.rdata = q.sysctl;
        OFF_WIDTH_SW:    d.rsp.rdata = {30'h0, q.wsw};
        default: begin
          d.rsp.rdata = 32'h0000_0000;
          d.rsp.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Ready flags are registered so that outputs stay flop driven;
    // one transfer per channel is in flight at a time.
    d.rsp.awready = !d.aw_full && !d.rsp.bvalid;
    d.rsp.wready  = !d.w_full && !d.rsp.bvalid;
    d.rsp.arready = !d.rsp.rvalid;

    // Internal bus error sources; watchdog ignores the flag state.
    d.bus_error = wd_expire
                | (bus_evt.wp_violation
                   & q.sysctl[BIT_WP_ERR_EN])
                | (bus_evt.cs_conflict
                   & q.sysctl[BIT_CONFL_EN]);

    // Width switch sequencer, started only by a rising enable.
    d.sw_en_prev = q.wsw[BIT_SW_EN];
    unique case (q.sw)
      SCB_SW_IDLE: begin
        if (q.wsw[BIT_SW_EN] && !q.sw_en_prev) begin
          d.sw      = SCB_SW_REQ;
          d.bus_req = 1'b1;
        end
      end
      SCB_SW_REQ: begin
        if (core.bus_granted) begin
          d.sw = SCB_SW_APPLY;
        end
      end
      SCB_SW_APPLY: begin
        d.width16 = q.wsw[BIT_WIDTH_SEL];
        d.sw      = SCB_SW_RELEASE;
      end
      SCB_SW_RELEASE: begin
        d.bus_req = 1'b0;
        d.sw      = SCB_SW_IDLE;
      end
    endcase

    // Control outputs follow the stored fields.
    d.ctl.freeze_timer_one      = q.sysctl[BIT_FRZ_T1];
    d.ctl.freeze_timer_two      = q.sysctl[BIT_FRZ_T2];
    d.ctl.freeze_watchdog_timer = q.sysctl[BIT_FRZ_WD];
    d.ctl.microcode_run         = q.sysctl[BIT_UCODE_EN];

    // Interrupt pending only reaches bus clear when unmasked.
    d.ctl.bus_clear = q.sysctl[BIT_CLEAR_MASK]
                    & core.irq_pending;

    // Grant is withheld for the whole locked cycle when split;
    // otherwise the arbiter grants regardless of the lock.
    d.ctl.grant_allow = !(q.sysctl[BIT_LOCK_SPLIT]
                          & core.lock_active);
    d.ctl.lock_split  = q.sysctl[BIT_LOCK_SPLIT]
                      & core.lock_active;
    d.ctl.cs_wait_on_write = q.sysctl[BIT_LOCK_SPLIT];

    // Extra wait for chip-select acks to external masters.
    d.ctl.cs_extra_wait = q.sysctl[BIT_EXT_WAIT];

    // Wait states for external-master accesses to internal space.
    // The first mode change arrives in async mode, so three waits
    // cover it without special handling.
    if (!q.sysctl[BIT_SYNC_ACC]) begin
      d.ctl.ext_wait_states = ASYNC_WAITS;
    end else if (q.sysctl[BIT_EXT_WAIT]) begin
      d.ctl.ext_wait_states = ONE_WAIT;
    end else begin
      d.ctl.ext_wait_states = SYNC_WAITS;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset loads constants only; outputs settle to their reset meaning.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q                     <= '0;
      q.sysctl              <= SYSCTL_RESET;
      q.wsw                 <= WIDTH_SW_RESET;
      q.sw                  <= SCB_SW_IDLE;
      q.ctl.grant_allow     <= 1'b1;
      q.ctl.ext_wait_states <= ASYNC_WAITS;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign axi_rsp          = q.rsp;
  assign ctl              = q.ctl;
  assign bus_error        = q.bus_error;
  assign core_bus_request = q.bus_req;
  assign data_width_16    = q.width16;

endmodule : scb_top
`default_nettype wire

// ### design/scb_wdog.sv
`timescale 1ns/1ps
`default_nettype none
module scb_wdog #(
  parameter int unsigned BASE_CYCLES = scb_pkg::WD_BASE_CYCLES
) (
  // Clock and reset.
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // Control.
  input  wire logic                        enable,
  input  wire logic [scb_pkg::WD_CNT_W-1:0] count_sel,
  // Bus cycle tracking.
  input  wire logic                        cycle_start,
  input  wire logic                        cycle_ack,
  // Timeout pulse.
  output var  logic                        expire
);
  import scb_pkg::*;

  typedef struct packed {
    logic                running;
    logic [WD_TMR_W-1:0] cnt;
    logic                expire;
  } scb_wdog_state_t;

  scb_wdog_state_t     q;
  scb_wdog_state_t     d;
  logic [WD_TMR_W-1:0] last;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Last count before expiry; the base doubles per code step.
  assign last = (WD_TMR_W'(BASE_CYCLES) << count_sel) - WD_TMR_W'(1);

  // While enabled, a new cycle always restarts, so a late ack cannot leak over.
  always_comb begin
    d        = q;
    d.expire = 1'b0;
    if (!enable) begin
      d.running = 1'b0;
    end else if (cycle_start) begin
      d.running = 1'b1;
      d.cnt     = '0;
    end else if (q.running) begin
      if (cycle_ack) begin
        d.running = 1'b0;
      end else if (q.cnt == last) begin
        d.running = 1'b0;
        d.expire  = 1'b1;
      end else begin
        d.cnt = q.cnt + WD_TMR_W'(1);
      end
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expire = q.expire;

endmodule : scb_wdog
`default_nettype wire

// ### dv/scb_chk.sv
`timescale 1ns/1ps
`default_nettype none
module scb_chk #(
  parameter int unsigned WD_BASE = 128
) (
  // Clock and reset.
  input wire logic                  aclk,
  input wire logic                  aresetn,
  // Watched ports of the top module.
  input wire scb_pkg::scb_axi_req_t axi_req,
  input wire scb_pkg::scb_axi_rsp_t axi_rsp,
  input wire scb_pkg::scb_bus_evt_t bus_evt,
  input wire scb_pkg::scb_core_t    core,
  input wire scb_pkg::scb_ctl_t     ctl,
  input wire logic                  bus_error,
  input wire logic                  core_bus_request,
  input wire logic                  data_width_16
);
  import scb_pkg::*;
  logic [15:0] wd_q;
  logic [15:0] wd_d;

  // Age of the open bus cycle; it saturates so a stale cycle never wraps.
  always_comb begin
    wd_d = wd_q;
    if (bus_evt.cycle_start) wd_d = 16'h0001;
    else if (bus_evt.cycle_ack) wd_d = 16'h0000;
    else if (wd_q != 16'h0000 && wd_q != 16'hFFFF) wd_d = wd_q + 16'h0001;
  end

  // Cycle age register.
  always_ff @(posedge aclk) begin
    if (!aresetn) wd_q <= 16'h0000;
    else wd_q <= wd_d;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  clear_mask_a: assert property (
    ctl.bus_clear |-> $past(core.irq_pending))
    else $error("bus clear without pending interrupt");
  grant_lock_a: assert property (
    !ctl.grant_allow |-> $past(core.lock_active) && ctl.cs_wait_on_write)
    else $error("grant withheld without split locked cycle");
  split_strobe_a: assert property (
    ctl.lock_split |-> !ctl.grant_allow && ctl.cs_wait_on_write)
    else $error("split locked cycle with grant allowed");
  wait_sel_a: assert property (
    ctl.ext_wait_states != 2'h3 |-> ctl.ext_wait_states[1] == 1'b0
      && ctl.ext_wait_states[0] == ctl.cs_extra_wait)
    else $error("synchronous wait count wrong");
  width_hold_a: assert property (
    !core_bus_request |=> $stable(data_width_16))
    else $error("bus width changed without bus request");
  width_cause_a: assert property (
    $changed(data_width_16) |-> $past(core.bus_granted))
    else $error("bus width changed before grant");
  req_hold_a: assert property (
    core_bus_request && !core.bus_granted |=> core_bus_request)
    else $error("bus request dropped before grant");
  req_drop_a: assert property (
    core_bus_request && core.bus_granted |-> ##[1:4] !core_bus_request)
    else $error("bus not returned after switch");
  err_cause_a: assert property (
    bus_error |-> $past(bus_evt.wp_violation) || $past(bus_evt.cs_conflict)
      || int'(wd_q) >= WD_BASE)
    else $error("bus error without cause");
  resp_hold_a: assert property (
    axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid)
    else $error("write response withdrawn");

  cover property (bus_error);
  cover property ($changed(data_width_16));
  cover property (ctl.lock_split);
  cover property (ctl.bus_clear);
endmodule : scb_chk
`default_nettype wire

// ### dv/scb_far_mdl.sv
`timescale 1ns/1ps
`default_nettype none
module scb_far_mdl (
  // Clock and reset.
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Grant latency in cycles, set per scenario.
  input  wire logic [3:0] grant_wait,
  // Bus handover with the width switch sequencer.
  input  wire logic       core_bus_request,
  output var  logic       bus_granted
);
  logic [3:0] cnt_q;

  // The core finishes its access before yielding, so grant lags request.
  always_ff @(posedge aclk) begin
    if (!aresetn || !core_bus_request) begin
      cnt_q       <= 4'h0;
      bus_granted <= 1'b0;
    end else if (cnt_q >= grant_wait) begin
      bus_granted <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : scb_far_mdl
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) \
  begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED at %0t: %s", $time, m); end end
module testbench;
  import scb_pkg::*;
  localparam int unsigned WDB = 4;
  localparam logic [7:0] SYS = OFF_SYSTEM_CTRL;
  localparam logic [7:0] WSW = OFF_WIDTH_SW;
  localparam scb_ctl_t CTL_RST = '{grant_allow: 1'b1,
    ext_wait_states: 2'h3, default: '0};
  localparam scb_ctl_t CTL_ON = '{grant_allow: 1'b0,
    ext_wait_states: 2'h1, default: '1};
  localparam scb_ctl_t CTL_SYNC = '{grant_allow: 1'b1, default: '0};
  logic         aclk;
  logic         aresetn;
  scb_axi_req_t req;
  scb_axi_rsp_t rsp;
  scb_bus_evt_t evt;
  scb_core_t    core;
  scb_ctl_t     ctl;
  logic         berr;
  logic         breq;
  logic         w16;
  logic         gnt;
  logic         irq;
  logic         lock;
  logic [3:0]   gwait;
  logic [31:0]  rd;
  logic [1:0]   rs;
  int           n_errors;
  int           n_tests;
  int           n_berr;
  int           k;

  assign core = '{irq_pending: irq, lock_active: lock, bus_granted: gnt};

  scb_top #(.WD_BASE(WDB)) DUT (.aclk(aclk), .aresetn(aresetn),
    .axi_req(req), .axi_rsp(rsp), .bus_evt(evt), .core(core), .ctl(ctl),
    .bus_error(berr), .core_bus_request(breq), .data_width_16(w16));

  scb_far_mdl u_far (.aclk(aclk), .aresetn(aresetn), .grant_wait(gwait),
    .core_bus_request(breq), .bus_granted(gnt));

  // Clock and bus error pulse counter.
  always #50 aclk = ~aclk;
  always @(posedge aclk) if (berr === 1'b1) n_berr <= n_berr + 1;

  task automatic results;
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  task automatic timeout;
    n_errors++;
    $display("CHECK FAILED at %0t: wait timed out", $time);
    results();
  endtask : timeout

  // Write: address and data offered together, each dropped when taken.
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int i;
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.bready  <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    if (i == 40) timeout();
    rs = rsp.bresp;
    req.bready <= 1'b0;
    @(posedge aclk);
  endtask : axw

  task automatic axr(input logic [7:0] a);
    int i;
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    if (i == 40) timeout();
    rd = rsp.rdata;
    rs = rsp.rresp;
    req.rready <= 1'b0;
    @(posedge aclk);
  endtask : axr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input string m);
    axr(a);
    `CHK(rd, e, m)
  endtask : rchk

  // One-cycle pulse on the bus event lines; the two extra edges let the
  // error pulse counter settle before a caller compares it.
  task automatic ev(input logic [3:0] m);
    evt <= m;
    @(posedge aclk);
    evt <= 4'h0;
    repeat (2) @(posedge aclk);
  endtask : ev

  // Width switch: the request must rise and fall within bounded time.
  task automatic sw(input logic [1:0] v, input logic e);
    int i;
    axw(WSW, {30'h0, v});
    for (i = 0; i < 40 && breq !== 1'b1; i++) @(posedge aclk);
    if (i == 40) timeout();
    for (i = 0; i < 40 && breq !== 1'b0; i++) @(posedge aclk);
    if (i == 40) timeout();
    `CHK(w16, e, "bus width")
  endtask : sw

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    req = '0;
    req.wstrb = 4'hF;
    evt = '0;
    irq = 1'b0;
    lock = 1'b0;
    gwait = 4'h0;
    n_errors = 0;
    n_tests = 0;
    n_berr = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(SYS, SYSCTL_RESET, "sysctl reset");
    rchk(WSW, 32'h0, "switch reset");
    `CHK(ctl, CTL_RST, "ctl reset")
    $display("test reset done");
    axw(SYS, 32'h00DF_F800);
    rchk(SYS, 32'h00DF_F800, "sysctl rw");
    irq <= 1'b1;
    lock <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK(ctl, CTL_ON, "ctl all on")
    axw(SYS, 32'h0000_1800);
    repeat (2) @(posedge aclk);
    `CHK(ctl, CTL_SYNC, "ctl sync")
    irq <= 1'b0;
    lock <= 1'b0;
    axw(SYS, 32'h0000_0800);
    rchk(SYS, 32'h0800_0800, "irq flag");
    $display("test controls done");
    k = n_berr;
    ev(4'h2);
    ev(4'h1);
    `CHK(n_berr, k, "masked errors")
    axw(SYS, 32'h0012_0800);
    ev(4'h2);
    `CHK(n_berr, k + 1, "wp error")
    ev(4'h1);
    `CHK(n_berr, k + 2, "conflict error")
    rchk(SYS, 32'h0B12_0800, "event flags");
    axw(SYS, 32'h0A12_0800);
    rchk(SYS, 32'h0112_0800, "two cleared");
    axw(SYS, 32'h0100_0800);
    rchk(SYS, 32'h0000_0800, "all cleared");
    $display("test events done");
    for (int c = 0; c < 8; c++) begin
      axw(SYS, 32'h0000_0800 | (32'(c) << 8));
      k = n_berr;
      ev(4'h8);
      repeat ((WDB << c) - 4) @(posedge aclk);
      `CHK(n_berr, k, "early timeout")
      repeat (8) @(posedge aclk);
      `CHK(n_berr, k + 1, "timeout")
    end
    rchk(SYS, 32'h0400_0F00, "timeout flag");
    axw(SYS, 32'h0400_0800);
    k = n_berr;
    ev(4'h8);
    ev(4'h4);
    repeat (12) @(posedge aclk);
    `CHK(n_berr, k, "acked cycle")
    repeat (4) ev(4'h8);
    `CHK(n_berr, k, "restarted cycle")
    ev(4'h4);
    axw(SYS, 32'h0000_0000);
    ev(4'h8);
    repeat (12) @(posedge aclk);
    `CHK(n_berr, k, "disabled watchdog")
    rchk(SYS, 32'h0, "no timeout flag");
    $display("test watchdog done");
    sw(2'b11, 1'b1);
    axw(WSW, 32'h1);
    repeat (6) @(posedge aclk);
    `CHK({breq, w16}, 2'b01, "no retrigger")
    axw(WSW, 32'h0);
    gwait <= 4'h6;
    sw(2'b01, 1'b0);
    $display("test width done");
    axr(8'h08);
    `CHK({rs, rd}, {RESP_SLVERR, 32'h0}, "unmapped read")
    axw(8'h10, 32'hFFFF_FFFF);
    `CHK(rs, RESP_SLVERR, "unmapped write")
    rchk(SYS, 32'h0, "no side effect");
    $display("test unmapped done");
    results();
  end
endmodule : testbench

bind scb_top scb_chk #(.WD_BASE(WD_BASE)) u_chk (.aclk(aclk),
  .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .bus_evt(bus_evt), .core(core), .ctl(ctl), .bus_error(bus_error),
  .core_bus_request(core_bus_request), .data_width_16(data_width_16));
`default_nettype wire
